/* File: logic/skip_timer_ops.sv */
// Execution of three conditional skips and the timer 1 load.
// Assumes the sequencer pulses exec_i once per decoded word, and presents
// operands on the same cycle; the program counter is advanced outside.
// Timer counting and the RAM and port storage sit outside this block.
// Operation
// [RQ1] Memory-bit skip: skip next instruction when selected RAM bit is zero.
// [RQ2] Carry skip: skip when carry is zero; carry left unchanged.
// [RQ3] Port skip: skip when port bit selected by Y (0..6) is zero.
// [RQ4] Timer 1 load: B goes to upper nibble of timer and reload.
// [RQ5] Timer 1 load: accumulator goes to lower nibble of both.
// [RQ6] Skip suppresses the next word; program counter still advances.
`timescale 1ns/1ps
`default_nettype none
module skip_timer_ops
    import skip_timer_pkg::*;
(
    input  wire logic                ref_clk_i,
    input  wire logic                rst_b_i,
    input  wire logic                exec_i,
    input  wire logic [2:0]          op_i,
    input  wire logic [BITSEL_W-1:0] bit_sel_i,
    input  wire logic [NIBBLE_W-1:0] ram_word_i,
    input  wire logic                carry_flag_i,
    input  wire logic [YSEL_W-1:0]   y_reg_i,
    input  wire logic [PORT_W-1:0]   port_latch_i,
    input  wire logic [NIBBLE_W-1:0] acc_i,
    input  wire logic [NIBBLE_W-1:0] b_reg_i,
    output logic                     suppress_next_o,
    output logic                     timer1_load_o,
    output logic [TIMER_W-1:0]       timer1_value_o,
    output logic [TIMER_W-1:0]       timer1_reload_register_o
);
    op_t op;
    logic skip_nxt;
    logic skip_r;
    logic next_is_exec;
    logic load_req;

    assign op = op_t'(op_i);

    // Selected bit of a nibble or port word
    function automatic logic pick_bit(input logic [PORT_W-1:0] w, input logic [3:0] s);
        logic r;
        r = 1'b0;
        if (s <= Y_MAX)
        begin
            r = w[s[2:0]];
        end
        return r;
    endfunction

    // Op decode used by the plain-word check; illegal codes never skip
    function automatic logic is_skip_op(input op_t o);
        logic r;
        r = 1'b0;
        unique case (o)
            OP_SKIP_MEM_BIT,
            OP_SKIP_IF_CARRY_CLEAR,
            OP_SKIP_IF_PORT_BIT_CLEAR:
            begin
                r = 1'b1;
            end
            default:
            begin
                r = 1'b0;
            end
        endcase
        return r;
    endfunction

    // Skip test; a word that is itself suppressed decides nothing
    always_comb
    begin
        skip_nxt = 1'b0;
        unique case (op)
            OP_SKIP_MEM_BIT:
            begin
                skip_nxt = !pick_bit({3'b000, ram_word_i}, {2'b00, bit_sel_i}); // RQ1
            end
            OP_SKIP_IF_CARRY_CLEAR:
            begin
                skip_nxt = !carry_flag_i; // RQ2
            end
            OP_SKIP_IF_PORT_BIT_CLEAR:
            begin
                // Y above 6 is undefined; treated as no skip
                skip_nxt = (y_reg_i <= Y_MAX) && !pick_bit(port_latch_i, y_reg_i); // RQ3
            end
            default:
            begin
                skip_nxt = 1'b0;
            end
        endcase
    end

    assign next_is_exec = exec_i && !skip_r;

    // Skip flag holds until the next word passes by, executed or not
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            skip_r <= 1'b0;
        end
        else if (exec_i)
        begin
            skip_r <= next_is_exec && skip_nxt; // RQ6
        end
    end

    always_comb suppress_next_o = skip_r; // RQ6

    assign load_req = next_is_exec && (op == OP_LOAD_TIMER1_FROM_ACC_AND_B);

    // Carry is only read here, so it stays unchanged by construction
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            timer1_load_o <= 1'b0;
        end
        else
        begin
            timer1_load_o <= load_req; // RQ4 RQ5
        end
    end

    // Timer and reload share one load strobe so they never disagree
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            timer1_value_o <= TIMER_RESET;
        end
        else if (load_req)
        begin
            timer1_value_o[TIMER_W-1:TIMER_HI_LSB] <= b_reg_i; // RQ4
            timer1_value_o[TIMER_HI_LSB-1:0]       <= acc_i; // RQ5
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            timer1_reload_register_o <= TIMER_RESET;
        end
        else if (load_req)
        begin
            timer1_reload_register_o[TIMER_W-1:TIMER_HI_LSB] <= b_reg_i; // RQ4
            timer1_reload_register_o[TIMER_HI_LSB-1:0]       <= acc_i; // RQ5
        end
    end

    sequence s_load_req;
        exec_i && !skip_r && op == OP_LOAD_TIMER1_FROM_ACC_AND_B;
    endsequence

    // Word classes the checks below are built from
    sequence s_port_out_of_range;
        exec_i && !skip_r && op == OP_SKIP_IF_PORT_BIT_CLEAR && y_reg_i > Y_MAX;
    endsequence

    sequence s_plain_word;
        exec_i && !skip_r && !is_skip_op(op);
    endsequence

    sequence s_no_word;
        !exec_i;
    endsequence

    sequence s_no_load_req;
        !exec_i || skip_r || op != OP_LOAD_TIMER1_FROM_ACC_AND_B;
    endsequence

    a_timer_hi_load: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RQ4
        s_load_req |=> timer1_value_o[7:4] == $past(b_reg_i)
                    && timer1_reload_register_o[7:4] == $past(b_reg_i))
        else $error("Timer upper nibble not loaded from B");

    a_timer_lo_load: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RQ5
        s_load_req |=> timer1_value_o[3:0] == $past(acc_i) && timer1_load_o
                    && timer1_reload_register_o[3:0] == $past(acc_i))
        else $error("Timer lower nibble not loaded from accumulator");

    a_mem_bit_skip: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RQ1
        exec_i && !skip_r && op == OP_SKIP_MEM_BIT |=> suppress_next_o == !$past(ram_word_i[bit_sel_i]))
        else $error("Memory-bit skip wrong");

    a_carry_skip: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RQ2
        exec_i && !skip_r && op == OP_SKIP_IF_CARRY_CLEAR |=> suppress_next_o == !$past(carry_flag_i))
        else $error("Carry skip wrong");

    a_port_skip: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RQ3
        exec_i && !skip_r && op == OP_SKIP_IF_PORT_BIT_CLEAR && y_reg_i <= Y_MAX
        |=> suppress_next_o == !$past(port_latch_i[y_reg_i[2:0]]))
        else $error("Port skip wrong");

    a_skip_no_load: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RQ6
        exec_i && skip_r |=> !timer1_load_o && !suppress_next_o)
        else $error("Suppressed word took effect");

    a_port_range_runs: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RQ3
        s_port_out_of_range |=> !suppress_next_o)
        else $error("Port skip taken for Y above six");

    a_plain_op_runs: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RQ6
        s_plain_word |=> !suppress_next_o)
        else $error("Skip flag raised by a word that does not skip");

    a_skip_flag_holds: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RQ6
        s_no_word |=> $stable(suppress_next_o))
        else $error("Skip flag changed with no word presented");

    a_load_needs_word: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RQ4
        s_no_load_req |=> !timer1_load_o)
        else $error("Timer 1 load pulse without a load word");

    a_timer_holds: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RQ5
        s_no_load_req |=> $stable(timer1_value_o) && $stable(timer1_reload_register_o))
        else $error("Timer 1 changed without a load word");

    a_reload_tracks: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RQ4
        timer1_value_o == timer1_reload_register_o)
        else $error("Timer 1 and its reload register disagree");
endmodule
`default_nettype wire

/* File: logic/skip_timer_pkg.sv */
// Package for the skip and timer-1 load execution block.
// Assumes a 4-bit core with a one-cycle execute strobe from the sequencer.
package skip_timer_pkg;
    localparam int NIBBLE_W     = 4;
    localparam int TIMER_W      = 8;
    localparam int PORT_W       = 7;
    localparam int BITSEL_W     = 2;
    localparam int YSEL_W       = 4;
    localparam logic [3:0] Y_MAX = 4'h6;
    localparam int TIMER_HI_LSB = 4;
    localparam logic [7:0] TIMER_RESET = 8'h00;

    typedef enum logic [2:0]
    {
        OP_NONE,
        OP_SKIP_MEM_BIT,
        OP_SKIP_IF_CARRY_CLEAR,
        OP_SKIP_IF_PORT_BIT_CLEAR,
        OP_LOAD_TIMER1_FROM_ACC_AND_B
    } op_t;
endpackage

/* File: verification/tb.sv */
// Bench for the skip and timer 1 load block: random words against a model.
// Assumes the package and the design module are compiled ahead of this file.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import skip_timer_pkg::*;
    logic       clk = 0, rst_b = 0, exec = 0, carry = 0, sup, ld;
    logic [2:0] op = 0;
    logic [1:0] bsel = 0;
    logic [3:0] ram = 0, y = 0, a = 0, b = 0;
    logic [6:0] port = 0;
    logic [7:0] tv, rv;
    int         es = 0, el = 0, ev = 0, fails = 0, checks = 0;

    skip_timer_ops u_skip_timer_ops (.ref_clk_i(clk), .rst_b_i(rst_b), .exec_i(exec),
        .op_i(op), .bit_sel_i(bsel), .ram_word_i(ram), .carry_flag_i(carry), .y_reg_i(y),
        .port_latch_i(port), .acc_i(a), .b_reg_i(b), .suppress_next_o(sup),
        .timer1_load_o(ld), .timer1_value_o(tv), .timer1_reload_register_o(rv));

    initial
        forever #2 clk = ~clk;

    task automatic tally_and_finish;
        if (fails == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // At most one word per cycle, exec high three times in four, driven just after the edge; op spans illegal codes too
    task automatic drive_word;
        @(posedge clk);
        #1;
        exec = ($urandom_range(3) != 0);
        op = 3'($urandom_range(7));
        bsel = 2'($urandom);
        ram = 4'($urandom);
        carry = 1'($urandom);
        y = 4'($urandom);
        port = 7'($urandom);
        a = 4'($urandom);
        b = 4'($urandom);
    endtask

    task automatic chk(input string n, input logic [7:0] exp, input logic [7:0] seen);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // Model: reset clears all at once; a skipped word is consumed and does nothing else
    always @(posedge clk or negedge rst_b)
        if (!rst_b)
        begin
            es = 0;
            el = 0;
            ev = 0;
        end
        else
        begin
            el = 0;
            if (exec && es != 0)
                es = 0;
            else if (exec)
            begin
                es = (op == 1) ? !ram[bsel] : (op == 2) ? !carry :
                     (op == 3 && y < 7) ? !port[y[2:0]] : 0;
                if (op == 4)
                begin
                    el = 1;
                    ev = {b, a};
                end
            end
        end

    // Compare mid-cycle, well clear of both edges; reset values are checked too
    always @(negedge clk)
    begin
        chk("suppress", 8'(es), {7'h00, sup});
        chk("load", 8'(el), {7'h00, ld});
        chk("timer", 8'(ev), tv);
        chk("reload", 8'(ev), rv);
    end

    initial
    begin
        void'($urandom(32'hb0326c1b));
        repeat (20) @(posedge clk);
        #1 rst_b = 1;
        // Y spans 0..15 so out-of-range port selects are hit too
        repeat (3000)
        begin
            drive_word();
        end
        // Mid-run reset: flags and timer must drop at once, words resume after
        rst_b = 0;
        repeat (3)
        begin
            drive_word();
        end
        rst_b = 1;
        repeat (1000)
        begin
            drive_word();
        end
        tally_and_finish();
    end

    // About 4030 cycles are planned; allow roughly two and a half times that
    initial
    begin
        #40000;
        fails++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
